// file: logic/lsc_pkg.sv
// constants, field layouts and decode tables for the limiter stage register bank
package lsc_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // register addresses
   localparam logic [7:0] ADDR_POWER_LEVEL = 8'h08;
   localparam logic [7:0] ADDR_MID_TIMING  = 8'h09;
   localparam logic [7:0] ADDR_FAST_CTRL   = 8'h0a;

   // power ceiling field
   localparam int unsigned PO_LSB = 0;
   localparam int unsigned PO_W   = 4;
   localparam logic [3:0] PO_SPK_DEFAULT = 4'h6;
   localparam logic [3:0] PO_SPK_MAX     = 4'h8;
   localparam logic [3:0] PO_RCV_OFF     = 4'h9;

   // middle timing fields
   localparam int unsigned MAT_LSB = 2;
   localparam int unsigned MAT_W   = 3;
   localparam int unsigned MFA_LSB = 0;
   localparam int unsigned MFA_W   = 2;
   localparam logic [2:0] MAT_DEFAULT = 3'h2;
   localparam logic [1:0] MFA_DEFAULT = 2'h0;

   // fast control fields
   localparam int unsigned FAT_LSB = 1;
   localparam int unsigned FAT_W   = 2;
   localparam int unsigned FPD_BIT = 0;
   localparam logic [1:0] FAT_DEFAULT = 2'h1;
   localparam logic       FPD_DEFAULT = 1'h0;
   localparam logic [4:0] FAST_RSVD_VALUE = 5'h09;
   localparam int unsigned FAST_RSVD_LSB  = 3;

   // decoded figures: power in mW, rates in nanoseconds per dB
   localparam int unsigned MW_W   = 12;
   localparam int unsigned RATE_W = 18;
   localparam logic [11:0] PO_BASE_MW = 12'h190; // 400 mW
   localparam logic [11:0] PO_STEP_MW = 12'h0c8; // 200 mW

   typedef logic [17:0] lsc_rate_t;

   // reserved-code substitution, mode dependent
   function automatic logic [3:0] lsc_filter_ceiling(input logic [3:0] code, input logic spk);
      if (!spk)
         lsc_filter_ceiling = PO_RCV_OFF;
      else if (code > PO_SPK_MAX)
         lsc_filter_ceiling = PO_SPK_DEFAULT;
      else
         lsc_filter_ceiling = code;
   endfunction

   function automatic lsc_rate_t lsc_mid_attack(input logic [2:0] code);
      case (code)
         3'h0: lsc_mid_attack = 18'h000a0;    // 0.16
         3'h1: lsc_mid_attack = 18'h00140;    // 0.32
         3'h2: lsc_mid_attack = 18'h00280;    // 0.64
         3'h3: lsc_mid_attack = 18'h00a00;    // 2.56
         3'h4: lsc_mid_attack = 18'h02800;    // 10.24
         3'h5: lsc_mid_attack = 18'h0a028;    // 41
         3'h6: lsc_mid_attack = 18'h14050;    // 82
         default: lsc_mid_attack = 18'h280a0; // 164
      endcase
   endfunction

   function automatic lsc_rate_t lsc_mid_first(input logic [1:0] code);
      case (code)
         2'h0: lsc_mid_first = 18'h000a0;    // 0.16
         2'h1: lsc_mid_first = 18'h00280;    // 0.64
         2'h2: lsc_mid_first = 18'h00a00;    // 2.56
         default: lsc_mid_first = 18'h02800; // 10.24
      endcase
   endfunction

   function automatic lsc_rate_t lsc_fast_attack(input logic [1:0] code);
      case (code)
         2'h0: lsc_fast_attack = 18'h00028;    // 0.04
         2'h1: lsc_fast_attack = 18'h00050;    // 0.08
         2'h2: lsc_fast_attack = 18'h000a0;    // 0.16
         default: lsc_fast_attack = 18'h00140; // 0.32
      endcase
   endfunction

endpackage

// file: logic/lsc_ceiling_decode.sv
// power ceiling code to output power figure
`timescale 1ns/1ns
`default_nettype none
module lsc_ceiling_decode
   import lsc_pkg::*;
(
   input  wire logic [3:0]  code,        // stored ceiling code
   input  wire logic        spk,         // speaker mode selected
   output logic      [11:0] power_mw,    // ceiling in mW, 0 when stage off
   output logic             stage_off    // middle stage disabled
);
   logic [3:0] eff;

   always_comb begin
      eff       = lsc_filter_ceiling(code, spk);
      stage_off = (eff == PO_RCV_OFF);
      if (stage_off)
         power_mw = '0;
      else
         power_mw = PO_BASE_MW + 12'(PO_STEP_MW * {8'h00, eff});
   end
endmodule
`default_nettype wire

// file: logic/lsc_regs.sv
// configuration register bank for the middle and fast limiter stages
`timescale 1ns/1ns
`default_nettype none
module lsc_regs
   import lsc_pkg::*;
(
   input  wire logic              sys_clk,               // 100 MHz system clock
   input  wire logic              rst_b,                 // synchronous reset, active low
   input  wire logic              speaker_mode_select,   // 1 speaker, 0 receiver
   input  wire logic [ADDR_W-1:0] reg_addr,              // register address
   input  wire logic [DATA_W-1:0] reg_wdata,             // write data
   input  wire logic              reg_wr,                // write strobe
   input  wire logic              reg_rd,                // read strobe
   output logic      [DATA_W-1:0] reg_rdata,             // read data, valid with reg_rvalid
   output logic                   reg_rvalid,            // read answer pulse
   output logic      [3:0]        middle_stage_power_ceiling,      // effective ceiling code
   output logic      [MW_W-1:0]   middle_stage_power_mw,           // ceiling in mW
   output logic                   middle_stage_off,                // middle stage disabled
   output lsc_rate_t              middle_stage_attack_rate,        // ns per dB
   output lsc_rate_t              middle_stage_first_attack_rate,  // ns per dB
   output lsc_rate_t              fast_stage_attack_rate,          // ns per dB
   output logic                   fast_stage_powerdown             // fast stage powered down
);

   logic [3:0] po_q;
   logic [2:0] mat_q;
   logic [1:0] mfa_q;
   logic [1:0] fat_q;
   logic       fpd_q;
   logic [7:0] rdata_d;
   logic [MW_W-1:0] dec_mw;
   logic            dec_off;

   logic wr_po, wr_mt, wr_fc;
   assign wr_po = reg_wr && (reg_addr == ADDR_POWER_LEVEL);
   assign wr_mt = reg_wr && (reg_addr == ADDR_MID_TIMING);
   assign wr_fc = reg_wr && (reg_addr == ADDR_FAST_CTRL);

   // power ceiling field; reset default follows the mode
   always_ff @(posedge sys_clk) begin
      if (!rst_b)
         po_q <= lsc_filter_ceiling(PO_SPK_DEFAULT, speaker_mode_select);
      else if (wr_po)
         po_q <= lsc_filter_ceiling(reg_wdata[PO_LSB +: PO_W], speaker_mode_select);
   end

   // middle timing fields
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         mat_q <= MAT_DEFAULT;
         mfa_q <= MFA_DEFAULT;
      end else if (wr_mt) begin
         mat_q <= reg_wdata[MAT_LSB +: MAT_W];
         mfa_q <= reg_wdata[MFA_LSB +: MFA_W];
      end
   end

   // fast stage fields
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         fat_q <= FAT_DEFAULT;
         fpd_q <= FPD_DEFAULT;
      end else if (wr_fc) begin
         fat_q <= reg_wdata[FAT_LSB +: FAT_W];
         fpd_q <= reg_wdata[FPD_BIT];
      end
   end

   // read mux; reserved bits and unmapped addresses read fixed values
   always_comb begin
      rdata_d = '0;
      case (reg_addr)
         ADDR_POWER_LEVEL: rdata_d[PO_LSB +: PO_W] = po_q;
         ADDR_MID_TIMING: begin
            rdata_d[MAT_LSB +: MAT_W] = mat_q;
            rdata_d[MFA_LSB +: MFA_W] = mfa_q;
         end
         ADDR_FAST_CTRL: begin
            rdata_d[FAST_RSVD_LSB +: 5] = FAST_RSVD_VALUE;
            rdata_d[FAT_LSB +: FAT_W]   = fat_q;
            rdata_d[FPD_BIT]            = fpd_q;
         end
         default: rdata_d = '0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         reg_rdata  <= '0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= rdata_d;
      end
   end

   // mode-dependent decode of the stored ceiling
   lsc_ceiling_decode u_ceiling (
      .code      (po_q),
      .spk       (speaker_mode_select),
      .power_mw  (dec_mw),
      .stage_off (dec_off)
   );

   // registered decoded outputs, one cycle behind the fields
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         middle_stage_power_ceiling <= '0;
         middle_stage_power_mw      <= '0;
         middle_stage_off           <= 1'b0;
      end else begin
         middle_stage_power_ceiling <= lsc_filter_ceiling(po_q, speaker_mode_select);
         middle_stage_power_mw      <= dec_mw;
         middle_stage_off           <= dec_off;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         middle_stage_attack_rate       <= '0;
         middle_stage_first_attack_rate <= '0;
         fast_stage_attack_rate         <= '0;
         fast_stage_powerdown           <= 1'b0;
      end else begin
         middle_stage_attack_rate       <= lsc_mid_attack(mat_q);
         middle_stage_first_attack_rate <= lsc_mid_first(mfa_q);
         fast_stage_attack_rate         <= lsc_fast_attack(fat_q);
         fast_stage_powerdown           <= fpd_q;
      end
   end

   // checks
   sequence spk_bad_write_s;
      wr_po && speaker_mode_select && (reg_wdata[PO_LSB +: PO_W] > PO_SPK_MAX);
   endsequence

   sequence rcv_write_s;
      wr_po && !speaker_mode_select;
   endsequence

   sequence fast_read_s;
      reg_rd && (reg_addr == ADDR_FAST_CTRL);
   endsequence

   spk_reserved_sub_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      spk_bad_write_s |=> (po_q == PO_SPK_DEFAULT))
      else $error("reserved speaker ceiling not replaced by default");

   rcv_forced_off_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      rcv_write_s |=> (po_q == PO_RCV_OFF))
      else $error("receiver ceiling not forced to off code");

   spk_power_decode_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (speaker_mode_select && (po_q <= PO_SPK_MAX))
      |=> (middle_stage_power_mw == PO_BASE_MW + 12'(PO_STEP_MW * {8'h00, $past(po_q)})))
      else $error("speaker ceiling power decoded wrongly");

   power_rsvd_zero_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == ADDR_POWER_LEVEL) |=> reg_rvalid && (reg_rdata[7:4] == 4'h0))
      else $error("ceiling register upper bits not zero");

   mid_rsvd_zero_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == ADDR_MID_TIMING) |=> (reg_rdata[7:5] == 3'h0))
      else $error("middle timing upper bits not zero");

   mid_attack_write_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      wr_mt |=> ##1 (middle_stage_attack_rate == lsc_mid_attack($past(reg_wdata[MAT_LSB +: MAT_W], 2))))
      else $error("middle attack rate not following write");

   mid_first_write_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      wr_mt |=> ##1 (middle_stage_first_attack_rate == lsc_mid_first($past(reg_wdata[MFA_LSB +: MFA_W], 2))))
      else $error("middle first attack rate not following write");

   fast_readback_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      fast_read_s |=> (reg_rdata[FAT_LSB +: FAT_W] == $past(fat_q))
                      && (reg_rdata[FPD_BIT] == $past(fpd_q))
                      && (reg_rdata[7:3] == FAST_RSVD_VALUE))
      else $error("fast register read back wrong");

   fast_powerdown_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      wr_fc |=> ##1 (fast_stage_powerdown == $past(reg_wdata[FPD_BIT], 2)))
      else $error("fast stage power-down not following bit 0");

   mode_decode_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      !speaker_mode_select |=> middle_stage_off && (middle_stage_power_ceiling == PO_RCV_OFF))
      else $error("receiver mode not reflected in ceiling decode");

   fast_attack_write_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      wr_fc |=> ##1 (fast_stage_attack_rate == lsc_fast_attack($past(reg_wdata[FAT_LSB +: FAT_W], 2))))
      else $error("fast attack rate not following write");

   mid_readback_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == ADDR_MID_TIMING) |=> (reg_rdata[MAT_LSB +: MAT_W] == $past(mat_q))
                                                  && (reg_rdata[MFA_LSB +: MFA_W] == $past(mfa_q)))
      else $error("middle timing register read back wrong");

   ceiling_readback_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == ADDR_POWER_LEVEL) |=> (reg_rdata[PO_LSB +: PO_W] == $past(po_q)))
      else $error("ceiling register read back wrong");

   fast_reset_default_a: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      $rose(rst_b) |-> (fpd_q == FPD_DEFAULT) && (fat_q == FAT_DEFAULT))
      else $error("fast register not at reset defaults");

endmodule
`default_nettype wire

// file: tb/lsc_host_model.sv
// host model driving the register port of the limiter stage bank
`timescale 1ns/1ns
`default_nettype none
module lsc_host_model
   import lsc_pkg::*;
(
   input  wire logic              sys_clk,    // system clock
   output logic      [ADDR_W-1:0] reg_addr,   // register address
   output logic      [DATA_W-1:0] reg_wdata,  // write data
   output logic                   reg_wr,     // write strobe
   output logic                   reg_rd,     // read strobe
   input  wire logic [DATA_W-1:0] reg_rdata,  // read data
   input  wire logic              reg_rvalid, // read answer pulse
   output logic                   rd_ok       // answer seen one cycle after the strobe
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rd_ok = 1'b0;
   end

   // released lines show the inverse so a stale value is never mistaken for a live one
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      rd_ok = reg_rvalid;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// file: tb/lsc_regs_tb_top.sv
// self-checking bench for the limiter stage register bank
`timescale 1ns/1ns
`default_nettype none
module lsc_regs_tb_top;
   import lsc_pkg::*;
   logic       sys_clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       spk = 1'b1;
   logic       rd_ok, wr, rd, rvalid, m_off, f_pd;
   logic [7:0] addr, wdata, rdata, got;
   logic [3:0] ceil, st_c;
   logic [11:0] mw;
   lsc_rate_t  m_at, m_fa, f_at;
   logic [4:0] st9;
   logic [2:0] sta;
   int         failures = 0;
   int         checked = 0;
   int         cyc = 0;
   int         seed = 49726;
   int         mid_t[8] = '{160, 320, 640, 2560, 10240, 41000, 82000, 164000};
   int         fst_t[4] = '{160, 640, 2560, 10240};
   int         fat_t[4] = '{40, 80, 160, 320};

   lsc_regs u_lsc_regs (.sys_clk(sys_clk), .rst_b(rst_b), .speaker_mode_select(spk),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .middle_stage_power_ceiling(ceil), .middle_stage_power_mw(mw),
      .middle_stage_off(m_off), .middle_stage_attack_rate(m_at),
      .middle_stage_first_attack_rate(m_fa), .fast_stage_attack_rate(f_at),
      .fast_stage_powerdown(f_pd));

   lsc_host_model u_lsc_host_model (.sys_clk(sys_clk), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid), .rd_ok(rd_ok));

   always #5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end

   task automatic results;
      if (failures == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // effective ceiling under the current mode
   function automatic logic [3:0] eff(input logic [3:0] c, input logic s);
      return !s ? 4'h9 : (c > 4'h8) ? 4'h6 : c;
   endfunction

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      u_lsc_host_model.read(a, got);
      chk(rd_ok, 1'b1);
      chk(got, e);
   endtask

   task automatic check_all;
      logic [3:0] e;
      e = eff(st_c, spk);
      @(negedge sys_clk);
      chk(ceil, e);
      chk(mw, (e == 4'h9) ? 0 : 400 + 200 * e);
      chk(m_off, e == 4'h9);
      chk(m_at, mid_t[st9[4:2]]);
      chk(m_fa, fst_t[st9[1:0]]);
      chk(f_at, fat_t[sta[2:1]]);
      chk(f_pd, sta[0]);
      rdchk(8'h08, {4'h0, st_c});
      rdchk(8'h09, {3'h0, st9});
      rdchk(8'h0a, {5'h09, sta});
   endtask

   initial begin
      logic [7:0] a, d;
      repeat (12) @(negedge sys_clk);
      rst_b = 1'b1;
      st_c = 4'h6;
      st9 = 5'h08;
      sta = 3'h2;
      check_all();
      for (int i = 0; i < 300; i++) begin
         a = 8'h08 + 8'($unsigned($random(seed)) % 4);
         d = 8'($random(seed));
         spk = (i < 16) ? 1'b1 : 1'($random(seed));
         if (i < 16) begin
            a = 8'h08;
            d[3:0] = 4'(i);
         end else if (i < 24) begin
            a = 8'h09;
            d[4:2] = 3'(i);
         end
         u_lsc_host_model.write(a, d);
         if (a == 8'h08)
            st_c = spk ? ((d[3:0] > 4'h8) ? 4'h6 : d[3:0]) : 4'h9;
         if (a == 8'h09)
            st9 = d[4:0];
         if (a == 8'h0a)
            sta = d[2:0];
         if (a == 8'h0b)
            rdchk(a, 8'h00);
         check_all();
      end
      // reset again in receiver mode
      spk = 1'b0;
      rst_b = 1'b0;
      repeat (2) @(negedge sys_clk);
      rst_b = 1'b1;
      st_c = 4'h9;
      st9 = 5'h08;
      sta = 3'h2;
      check_all();
      results();
   end
endmodule
`default_nettype wire
